// File: tb_terminal_command_decoder.sv
// Self-checking bench for the terminal command decoder
`timescale 1ns/1ns
`include "tcd_defines.svh"
module tb_terminal_command_decoder;
   logic clk_i = 1'b0;
   logic reset_i = 1'b1;
   logic [9:0] terminal_i, press = 10'h000, chatter = 10'h000;
   logic [6:0] s_axi_awaddr_i = 7'h00, s_axi_araddr_i = 7'h00;
   logic [31:0] s_axi_wdata_i = 32'h0, s_axi_rdata_o;
   logic [3:0] s_axi_wstrb_i = 4'hf, ref_index_o;
   logic s_axi_awvalid_i = 1'b0, s_axi_wvalid_i = 1'b0;
   logic s_axi_arvalid_i = 1'b0;
   logic s_axi_bready_i = 1'b1, s_axi_rready_i = 1'b1;
   logic s_axi_awready_o, s_axi_wready_o, s_axi_bvalid_o;
   logic s_axi_arready_o, s_axi_rvalid_o, run_o, reverse_o;
   logic [1:0] s_axi_bresp_o, s_axi_rresp_o, ref_target_o;
   logic [1:0] ramp_set_o, motor_sel_o;
   logic [15:0] freq_ref_o, setpoint_o;
   int n_fail = 0, n_compared = 0, cyc = 0, seed = 28;
   logic [33:0] expq[$];
   // Mode, levels {enable, rev, fwd}, expected run and reverse
   logic [6:0] seq[26] = '{7'h06, 7'h0b, 7'h0c, 7'h00, 7'h26, 7'h2f,
      7'h20, 7'h28, 7'h20, 7'h50, 7'h56, 7'h52, 7'h5b, 7'h53, 7'h56,
      7'h44, 7'h40, 7'h50, 7'h5e, 7'h40, 7'h70, 7'h76, 7'h7f, 7'h7b,
      7'h72, 7'h60};

   always #2 clk_i = ~clk_i;

   tcd_switch_model u_tcd_switch_model (.clk_i, .press_i(press),
      .chatter_i(chatter), .terminal_o(terminal_i));
   // Short tick keeps the filter times in tens of cycles
   tcd_top #(.TICK_CYCLES(4)) u_tcd_top (.clk_i, .reset_i, .terminal_i,
      .s_axi_awaddr_i, .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wdata_i,
      .s_axi_wstrb_i, .s_axi_wvalid_i, .s_axi_wready_o, .s_axi_bresp_o,
      .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_araddr_i, .s_axi_arvalid_i,
      .s_axi_arready_o, .s_axi_rdata_o, .s_axi_rresp_o, .s_axi_rvalid_o,
      .s_axi_rready_i, .run_o, .reverse_o, .ref_index_o, .ramp_set_o,
      .motor_sel_o, .ref_target_o, .freq_ref_o, .setpoint_o);

   task automatic chk(input logic [33:0] seen, input logic [33:0] exp);
      n_compared++;
      if (seen !== exp)
      begin
         n_fail++;
         $display("wrong value at %0t: got %h expected %h", $time, seen, exp);
      end
   endtask

   task automatic end_sim;
      if (n_fail == 0 && n_compared > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // Sampled before the edge so the handshake is read without a race
   task automatic wr(input logic [6:0] a, input logic [31:0] d,
      input logic [1:0] r = 2'h0);
      logic aw, w, b;
      b = 1'b0;
      expq.push_back({r, 32'h0});
      s_axi_awaddr_i <= a;
      s_axi_wdata_i <= d;
      s_axi_awvalid_i <= 1'b1;
      s_axi_wvalid_i <= 1'b1;
      while (!b)
      begin
         @(negedge clk_i);
         aw = s_axi_awvalid_i && s_axi_awready_o;
         w = s_axi_wvalid_i && s_axi_wready_o;
         b = s_axi_bvalid_o;
         @(posedge clk_i);
         if (aw)
            s_axi_awvalid_i <= 1'b0;
         if (w)
            s_axi_wvalid_i <= 1'b0;
      end
   endtask

   task automatic rd(input logic [6:0] a, input logic [31:0] d,
      input logic [1:0] r = 2'h0);
      logic ar, rv;
      rv = 1'b0;
      expq.push_back({r, d});
      s_axi_araddr_i <= a;
      s_axi_arvalid_i <= 1'b1;
      while (!rv)
      begin
         @(negedge clk_i);
         ar = s_axi_arvalid_i && s_axi_arready_o;
         rv = s_axi_rvalid_o;
         @(posedge clk_i);
         if (ar)
            s_axi_arvalid_i <= 1'b0;
      end
   endtask

   function automatic logic [31:0] st(input logic [9:0] t, input logic rn,
      input logic rv, input logic [3:0] ix, input logic [1:0] rp,
      input logic [1:0] mt);
      return {4'h0, mt, rp, ix, 2'h0, rv, rn, 6'h00, t};
   endfunction

   always @(posedge clk_i)
   begin
      if (s_axi_rvalid_o && s_axi_rready_i)
         chk({s_axi_rresp_o, s_axi_rdata_o}, expq.pop_front());
      else if (s_axi_bvalid_o && s_axi_bready_i)
         chk({s_axi_bresp_o, 32'h0}, expq.pop_front());
   end

   always @(posedge clk_i)
   begin
      cyc++;
      if (cyc == 20000)
      begin
         n_fail++;
         end_sim();
      end
   end

   initial
   begin
      int i, k;
      logic [9:0] t;
      logic [6:0] m;
      logic [15:0] rf;
      logic [1:0] rp, mt, pm;
      logic [3:0] ix;
      repeat (4) @(posedge clk_i);
      reset_i <= 1'b0;
      @(posedge clk_i);
      rd(`TCD_ADDR_CTRL, 32'h0);
      rd(`TCD_ADDR_FILT, 32'h0000_000a);
      rd(`TCD_ADDR_FSEL_LO, 32'h0000_0321);
      rd(`TCD_ADDR_MAXF, 32'h0000_1388);
      rd(`TCD_ADDR_STATUS, 32'h0);
      rd(7'h20, 32'h0, 2'h2);
      wr(7'h24, 32'h1, 2'h2);
      wr(`TCD_ADDR_FILT, 32'h7ff);
      rd(`TCD_ADDR_FILT, 32'h3e8);
      // Chattering contact must never pass a two-tick filter
      wr(`TCD_ADDR_FILT, 32'h2);
      press <= 10'h001;
      chatter <= 10'h001;
      repeat (12) @(posedge clk_i);
      rd(`TCD_ADDR_STATUS, 32'h0);
      chatter <= 10'h000;
      repeat (3) @(posedge clk_i);
      // Outputs read away from the edge that launches them
      @(negedge clk_i);
      chk(run_o, 1'b0);
      repeat (8) @(posedge clk_i);
      rd(`TCD_ADDR_STATUS, st(10'h001, 1'b1, 1'b0, 4'h0, 2'h0, 2'h0));
      wr(`TCD_ADDR_FILT, 32'h0);
      press <= 10'h000;
      wr(`TCD_ADDR_FSEL_LO, 32'h8765_4321);
      for (k = 0; k < 2; k++)
      begin
         wr(`TCD_ADDR_FSEL_HI, k ? 32'h98 : 32'hba);
         for (i = 0; i < 10; i++)
         begin
            t = 10'($random(seed));
            if (i == 0)
               t = 10'h3f8;
            t[2:0] = 3'h0;
            press <= t;
            repeat (4) @(posedge clk_i);
            rp = k ? {t[9], t[7] | t[8]} : {1'b0, t[7]};
            mt = k ? 2'h0 : t[9:8];
            rd(`TCD_ADDR_STATUS,
               st(t, 1'b0, 1'b0, t[6:3], rp, mt));
         end
      end
      for (i = 0; i < 4; i++)
      begin
         ix = 4'(i * 5);
         rf = 16'($random(seed)) & 16'h3fff;
         wr(7'h40 + 7'(4 * ix), {16'h0, rf});
         rf = (rf > 16'h2710) ? 16'h2710 : rf;
         rd(7'h40 + 7'(4 * ix), {16'h0, rf});
         press <= 10'(ix) << 3;
         repeat (4) @(posedge clk_i);
         @(negedge clk_i);
         chk(freq_ref_o, 16'(32'(rf) * 32'h1388 / 32'h2710));
         @(posedge clk_i);
         wr(`TCD_ADDR_CTRL, (i % 2) ? 32'h20 : 32'h10);
         repeat (4) @(posedge clk_i);
         @(negedge clk_i);
         chk(setpoint_o, rf);
         chk(ref_target_o, (i % 2) ? 2'h2 : 2'h1);
         @(posedge clk_i);
         wr(`TCD_ADDR_CTRL, 32'h0);
      end
      wr(`TCD_ADDR_CTRL, 32'h30);
      rd(`TCD_ADDR_CTRL, 32'h0);
      press <= 10'h000;
      pm = 2'h3;
      for (i = 0; i < 26; i++)
      begin
         m = seq[i];
         if (m[6:5] != pm)
            wr(`TCD_ADDR_CTRL, {30'h0, m[6:5]});
         pm = m[6:5];
         press <= {7'h00, m[4:2]};
         repeat (4) @(posedge clk_i);
         rd(`TCD_ADDR_STATUS, st({7'h00, m[4:2]}, m[1], m[0], 4'h0, 2'h0,
            2'h0));
      end
      end_sim();
   end
endmodule

bind tcd_top tcd_properties u_tcd_properties (.clk_i, .reset_i,
   .s_axi_awvalid_i, .s_axi_awready_o, .s_axi_wvalid_i, .s_axi_wready_o,
   .s_axi_bresp_o, .s_axi_bvalid_o, .s_axi_bready_i, .s_axi_arvalid_i,
   .s_axi_arready_o, .s_axi_rresp_o, .s_axi_rvalid_o, .s_axi_rready_i,
   .run_o, .reverse_o, .ref_index_o, .ramp_set_o, .motor_sel_o,
   .ref_target_o, .freq_ref_o, .setpoint_o);

// File: tcd_defines.svh
// Offsets, field positions, reset values and timing counts of the decoder
`ifndef TCD_DEFINES_SVH
`define TCD_DEFINES_SVH
`define TCD_ADDR_CTRL 7'h00
`define TCD_ADDR_FILT 7'h04
`define TCD_ADDR_FSEL_LO 7'h08
`define TCD_ADDR_FSEL_HI 7'h0c
`define TCD_ADDR_MAXF 7'h10
`define TCD_ADDR_STATUS 7'h14
`define TCD_ADDR_REF_BASE 7'h40
`define TCD_CTRL_MODE_LSB 0
`define TCD_CTRL_TGT_LSB 4
`define TCD_ST_RUN_BIT 16
`define TCD_ST_REV_BIT 17
`define TCD_ST_IDX_LSB 20
`define TCD_ST_RAMP_LSB 24
`define TCD_ST_MOTOR_LSB 26
`define TCD_MODE_RST 2'h0
`define TCD_FILT_RST_MS 10'h00a
`define TCD_FILT_MAX_MS 10'h3e8
`define TCD_FSEL_LO_RST 32'h0000_0321
`define TCD_FSEL_HI_RST 32'h0000_0000
`define TCD_MAXF_RST 16'h1388
`define TCD_FULL_SCALE 16'h2710
`define TCD_CLK_PERIOD_NS 4
`define TCD_TICK_NS 1000000
`define TCD_TICK_CYCLES (`TCD_TICK_NS / `TCD_CLK_PERIOD_NS)
`endif

// File: tcd_pkg.sv
// Types shared by the terminal command decoder
package tcd_pkg;
   // Terminal function codes
   typedef enum logic [3:0] {
      TCD_FN_NONE = 4'h0,
      TCD_FN_FWD_RUN = 4'h1,
      TCD_FN_REV_DIR = 4'h2,
      TCD_FN_THREE_LINE = 4'h3,
      TCD_FN_SEL0 = 4'h4,
      TCD_FN_SEL1 = 4'h5,
      TCD_FN_SEL2 = 4'h6,
      TCD_FN_SEL3 = 4'h7,
      TCD_FN_RAMP0 = 4'h8,
      TCD_FN_RAMP1 = 4'h9,
      TCD_FN_MOTOR0 = 4'ha,
      TCD_FN_MOTOR1 = 4'hb
   } tcd_func_t;

   typedef enum logic [1:0] {
      TCD_MODE_TWO_1 = 2'h0,
      TCD_MODE_TWO_2 = 2'h1,
      TCD_MODE_THREE_1 = 2'h2,
      TCD_MODE_THREE_2 = 2'h3
   } tcd_mode_t;

   typedef enum logic [1:0] {
      TCD_TGT_SPEED = 2'h0,
      TCD_TGT_PID = 2'h1,
      TCD_TGT_VF = 2'h2
   } tcd_target_t;

   typedef enum logic [2:0] {
      TCD_LS_STOP = 3'b001,
      TCD_LS_FWD = 3'b010,
      TCD_LS_REV = 3'b100
   } tcd_latch_t;

   // Terminal levels gathered by assigned function
   typedef struct packed {
      logic fwd_run;
      logic rev_dir;
      logic three_line;
      logic [3:0] sel;
      logic [1:0] ramp;
      logic [1:0] motor;
   } tcd_roles_t;
endpackage

// File: tcd_properties.sv
// Port-level properties of the terminal command decoder
`timescale 1ns/1ns
module tcd_properties
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // AXI4-Lite handshakes
   input wire logic s_axi_awvalid_i,
   input wire logic s_axi_awready_o,
   input wire logic s_axi_wvalid_i,
   input wire logic s_axi_wready_o,
   input wire logic [1:0] s_axi_bresp_o,
   input wire logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   input wire logic s_axi_arvalid_i,
   input wire logic s_axi_arready_o,
   input wire logic [1:0] s_axi_rresp_o,
   input wire logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Drive commands
   input wire logic run_o,
   input wire logic reverse_o,
   input wire logic [3:0] ref_index_o,
   input wire logic [1:0] ramp_set_o,
   input wire logic [1:0] motor_sel_o,
   input wire logic [1:0] ref_target_o,
   input wire logic [15:0] freq_ref_o,
   input wire logic [15:0] setpoint_o
);
   default clocking cb @(posedge clk_i);
   endclocking
   default disable iff (reset_i);

   property p_reset_out;
      $fell(reset_i) |-> !run_o && ref_index_o == 4'h0
         && ramp_set_o == 2'h0 && motor_sel_o == 2'h0;
   endproperty
   a_reset_out: assert property (p_reset_out)
      else $error("outputs not idle after reset");
   property p_b_after;
      s_axi_awvalid_i && s_axi_awready_o && s_axi_wvalid_i
         && s_axi_wready_o |=> ##1 s_axi_bvalid_o;
   endproperty
   a_b_after: assert property (p_b_after)
      else $error("write response late");
   property p_b_once;
      s_axi_bvalid_o && s_axi_bready_i |=> !s_axi_bvalid_o;
   endproperty
   a_b_once: assert property (p_b_once)
      else $error("write response repeated");
   property p_b_block;
      s_axi_bvalid_o |-> !s_axi_awready_o && !s_axi_wready_o;
   endproperty
   a_b_block: assert property (p_b_block)
      else $error("write taken while response pending");
   property p_r_after;
      s_axi_arvalid_i && s_axi_arready_o |=> s_axi_rvalid_o;
   endproperty
   a_r_after: assert property (p_r_after)
      else $error("read data late");
   property p_r_block;
      s_axi_rvalid_o |-> !s_axi_arready_o;
   endproperty
   a_r_block: assert property (p_r_block)
      else $error("read taken while data pending");
   property p_tgt;
      ref_target_o != 2'h3;
   endproperty
   a_tgt: assert property (p_tgt)
      else $error("illegal reference target");
   property p_freq_zero;
      (ref_target_o != 2'h0) [*3] |-> freq_ref_o == 16'h0;
   endproperty
   a_freq_zero: assert property (p_freq_zero)
      else $error("speed reference while not speed target");
   property p_sp_zero;
      (ref_target_o == 2'h0) [*3] |-> setpoint_o == 16'h0;
   endproperty
   a_sp_zero: assert property (p_sp_zero)
      else $error("setpoint while speed target");
   property p_resp;
      s_axi_rvalid_o |-> s_axi_rresp_o == 2'h0 || s_axi_rresp_o == 2'h2;
   endproperty
   a_resp: assert property (p_resp)
      else $error("bad read response code");

   c_rev: cover property (run_o && reverse_o);
   c_idx: cover property (ref_index_o == 4'hf);
   c_mot: cover property (motor_sel_o == 2'h3);
   c_err: cover property (s_axi_rvalid_o && s_axi_rresp_o == 2'h2);
endmodule

// File: tcd_switch_model.sv
// Contact model of the operator switches and push-buttons
`timescale 1ns/1ns
module tcd_switch_model
(
   // Clock
   input wire logic clk_i,
   // Contact requests
   input wire logic [9:0] press_i,
   input wire logic [9:0] chatter_i,
   // Terminal levels
   output logic [9:0] terminal_o
);
   logic tgl_r = 1'b0;
   // Bouncing contacts flip every cycle so no level looks stable
   always @(posedge clk_i)
      tgl_r <= ~tgl_r;
   // Operator holds each contact for as long as it is pressed
   assign terminal_o = press_i ^ (chatter_i & {10{tgl_r}});
endmodule

// File: tcd_top.sv
// Terminal command decoder with filter, role mapping and AXI4-Lite registers
// Notes on behaviour
// - Four select roles form a 4-bit index, bit3 most significant, 0..15.
// - The chosen reference scales so that 100.00% equals max frequency.
// - The chosen reference may feed speed, PID setpoint or V/F voltage.
// - Two ramp roles form a 2-bit index, set 1 to set 4.
// - Two motor roles form a 2-bit index, motor 1 to motor 4.
// - Each terminal is accepted only after a stable 0 to 1000 ms, 10 ms.
// - Command mode 0..3 picks two-line 1/2 or three-line 1/2, reset 0.
// - Two-line 1: forward alone runs forward, reverse alone reverse.
// - Two-line 2: run enable with direction off forward, on reverse.
// - Three-line 1: with enable on, a pulse starts forward or reverse.
// - In three-line modes loss of enable stops at once.
// - Three-line 1 keeps the latest accepted pulse as the direction.
// - Each of ten terminals takes its role from a function selection.
`timescale 1ns/1ns
`include "tcd_defines.svh"
module tcd_top
   import tcd_pkg::*;
#(
   parameter int N_TERM = 10,
   parameter int TICK_CYCLES = `TCD_TICK_CYCLES
)
(
   // Clock and reset
   input wire logic clk_i,
   input wire logic reset_i,
   // Raw input terminals
   input wire logic [N_TERM-1:0] terminal_i,
   // AXI4-Lite write
   input wire logic [6:0] s_axi_awaddr_i,
   input wire logic s_axi_awvalid_i,
   output logic s_axi_awready_o,
   input wire logic [31:0] s_axi_wdata_i,
   input wire logic [3:0] s_axi_wstrb_i,
   input wire logic s_axi_wvalid_i,
   output logic s_axi_wready_o,
   output logic [1:0] s_axi_bresp_o,
   output logic s_axi_bvalid_o,
   input wire logic s_axi_bready_i,
   // AXI4-Lite read
   input wire logic [6:0] s_axi_araddr_i,
   input wire logic s_axi_arvalid_i,
   output logic s_axi_arready_o,
   output logic [31:0] s_axi_rdata_o,
   output logic [1:0] s_axi_rresp_o,
   output logic s_axi_rvalid_o,
   input wire logic s_axi_rready_i,
   // Drive commands
   output logic run_o,
   output logic reverse_o,
   output logic [3:0] ref_index_o,
   output logic [1:0] ramp_set_o,
   output logic [1:0] motor_sel_o,
   output logic [1:0] ref_target_o,
   output logic [15:0] freq_ref_o,
   output logic [15:0] setpoint_o
);
   localparam logic [1:0] RESP_OKAY = 2'h0;
   localparam logic [1:0] RESP_SLVERR = 2'h2;

   logic [1:0] mode_r;
   logic [1:0] target_r;
   logic [9:0] filt_ms_r;
   logic [31:0] fsel_lo_r;
   logic [31:0] fsel_hi_r;
   logic [15:0] maxf_r;
   logic [15:0] ref_r [16];
   logic [N_TERM-1:0] stable_r;
   logic [9:0] cnt_r [N_TERM];
   logic [31:0] tick_cnt_r;
   logic tick_r;
   tcd_roles_t roles;
   tcd_roles_t roles_prev_r;
   tcd_latch_t latch_r;
   tcd_latch_t latch_nxt;
   logic run_nxt;
   logic rev_nxt;
   logic aw_hold_r;
   logic w_hold_r;
   logic [6:0] awaddr_r;
   logic [31:0] wdata_r;
   logic [3:0] wstrb_r;
   logic bvalid_r;
   logic [1:0] bresp_r;
   logic rvalid_r;
   logic [31:0] rdata_r;
   logic [1:0] rresp_r;
   logic do_write;
   logic [31:0] status;

   function automatic logic [31:0] merge(input logic [31:0] old,
      input logic [31:0] data, input logic [3:0] strb);
      logic [31:0] res;
      res = old;
      for (int b = 0; b < 4; b++)
      begin
         if (strb[b])
            res[b*8 +: 8] = data[b*8 +: 8];
      end
      return res;
   endfunction

   function automatic logic mapped(input logic [6:0] a);
      return (a[6] == 1'b1 && a[1:0] == 2'h0) ||
         a == `TCD_ADDR_CTRL || a == `TCD_ADDR_FILT ||
         a == `TCD_ADDR_FSEL_LO || a == `TCD_ADDR_FSEL_HI ||
         a == `TCD_ADDR_MAXF || a == `TCD_ADDR_STATUS;
   endfunction

   function automatic logic [3:0] fsel(input int t,
      input logic [31:0] lo, input logic [31:0] hi);
      logic [63:0] all;
      all = {hi, lo};
      return all[t*4 +: 4];
   endfunction

   function automatic logic [15:0] scale(input logic [15:0] pct,
      input logic [15:0] maxf);
      logic [31:0] prod;
      prod = (32'(pct) * 32'(maxf)) / 32'(`TCD_FULL_SCALE);
      return prod[15:0];
   endfunction

   // AXI4-Lite handshakes
   assign s_axi_awready_o = !aw_hold_r && !bvalid_r;
   assign s_axi_wready_o = !w_hold_r && !bvalid_r;
   assign s_axi_arready_o = !rvalid_r;
   assign s_axi_bvalid_o = bvalid_r;
   assign s_axi_bresp_o = bresp_r;
   assign s_axi_rvalid_o = rvalid_r;
   assign s_axi_rdata_o = rdata_r;
   assign s_axi_rresp_o = rresp_r;
   assign do_write = aw_hold_r && w_hold_r && !bvalid_r;

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         aw_hold_r <= 1'b0;
         w_hold_r <= 1'b0;
         awaddr_r <= 7'h00;
         wdata_r <= 32'h0000_0000;
         wstrb_r <= 4'h0;
         bvalid_r <= 1'b0;
         bresp_r <= 2'h0;
      end
      else
      begin
         if (s_axi_awvalid_i && s_axi_awready_o)
         begin
            aw_hold_r <= 1'b1;
            awaddr_r <= s_axi_awaddr_i;
         end
         if (s_axi_wvalid_i && s_axi_wready_o)
         begin
            w_hold_r <= 1'b1;
            wdata_r <= s_axi_wdata_i;
            wstrb_r <= s_axi_wstrb_i;
         end
         if (do_write)
         begin
            aw_hold_r <= 1'b0;
            w_hold_r <= 1'b0;
            bvalid_r <= 1'b1;
            bresp_r <= mapped(awaddr_r) ? RESP_OKAY : RESP_SLVERR;
         end
         else if (bvalid_r && s_axi_bready_i)
            bvalid_r <= 1'b0;
      end
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         rvalid_r <= 1'b0;
         rdata_r <= 32'h0000_0000;
         rresp_r <= 2'h0;
      end
      else if (s_axi_arvalid_i && s_axi_arready_o)
      begin
         rvalid_r <= 1'b1;
         rresp_r <= mapped(s_axi_araddr_i) ? RESP_OKAY : RESP_SLVERR;
         if (s_axi_araddr_i[6] && s_axi_araddr_i[1:0] == 2'h0)
            rdata_r <= {16'h0000, ref_r[s_axi_araddr_i[5:2]]};
         else
            case (s_axi_araddr_i)
               `TCD_ADDR_CTRL: rdata_r <= {26'h0, target_r, 2'h0, mode_r};
               `TCD_ADDR_FILT: rdata_r <= {22'h0, filt_ms_r};
               `TCD_ADDR_FSEL_LO: rdata_r <= fsel_lo_r;
               `TCD_ADDR_FSEL_HI: rdata_r <= fsel_hi_r;
               `TCD_ADDR_MAXF: rdata_r <= {16'h0000, maxf_r};
               `TCD_ADDR_STATUS: rdata_r <= status;
               default: rdata_r <= 32'h0000_0000;
            endcase
      end
      else if (rvalid_r && s_axi_rready_i)
         rvalid_r <= 1'b0;
   end

   // Configuration registers
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         mode_r <= `TCD_MODE_RST;
         target_r <= TCD_TGT_SPEED;
         filt_ms_r <= `TCD_FILT_RST_MS;
         fsel_lo_r <= `TCD_FSEL_LO_RST;
         fsel_hi_r <= `TCD_FSEL_HI_RST;
         maxf_r <= `TCD_MAXF_RST;
      end
      else if (do_write)
      begin
         logic [31:0] v;
         v = 32'h0000_0000;
         case (awaddr_r)
            `TCD_ADDR_CTRL:
            begin
               v = merge({26'h0, target_r, 2'h0, mode_r}, wdata_r, wstrb_r);
               mode_r <= v[`TCD_CTRL_MODE_LSB +: 2];
               // Code 3 has no destination, previous target kept
               if (v[`TCD_CTRL_TGT_LSB +: 2] != 2'h3)
                  target_r <= v[`TCD_CTRL_TGT_LSB +: 2];
            end
            `TCD_ADDR_FILT:
            begin
               v = merge({22'h0, filt_ms_r}, wdata_r, wstrb_r);
               if (v[31:10] != 22'h0 || v[9:0] > `TCD_FILT_MAX_MS)
                  filt_ms_r <= `TCD_FILT_MAX_MS;
               else
                  filt_ms_r <= v[9:0];
            end
            `TCD_ADDR_FSEL_LO:
               fsel_lo_r <= merge(fsel_lo_r, wdata_r, wstrb_r);
            `TCD_ADDR_FSEL_HI:
               fsel_hi_r <= merge(fsel_hi_r, wdata_r, wstrb_r) &
                  32'h0000_00ff;
            `TCD_ADDR_MAXF:
            begin
               v = merge({16'h0000, maxf_r}, wdata_r, wstrb_r);
               maxf_r <= v[15:0];
            end
            default:
               v = 32'h0000_0000;
         endcase
      end
   end

   // Reference table, clamped so that products stay in range
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         for (int i = 0; i < 16; i++)
            ref_r[i] <= 16'h0000;
      end
      else if (do_write && awaddr_r[6] && awaddr_r[1:0] == 2'h0)
      begin
         logic [31:0] v;
         v = merge({16'h0000, ref_r[awaddr_r[5:2]]}, wdata_r, wstrb_r);
         if (v[31:16] != 16'h0000 || v[15:0] > `TCD_FULL_SCALE)
            ref_r[awaddr_r[5:2]] <= `TCD_FULL_SCALE;
         else
            ref_r[awaddr_r[5:2]] <= v[15:0];
      end
   end

   // Millisecond enable for the filters
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r <= 1'b0;
      end
      else if (tick_cnt_r >= 32'(TICK_CYCLES - 1))
      begin
         tick_cnt_r <= 32'h0000_0000;
         tick_r <= 1'b1;
      end
      else
      begin
         tick_cnt_r <= tick_cnt_r + 32'h0000_0001;
         tick_r <= 1'b0;
      end
   end

   // A bounce back to the old level restarts the wait
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         stable_r <= '0;
         for (int t = 0; t < N_TERM; t++)
            cnt_r[t] <= 10'h000;
      end
      else
      begin
         for (int t = 0; t < N_TERM; t++)
         begin
            if (terminal_i[t] == stable_r[t])
               cnt_r[t] <= 10'h000;
            else if (filt_ms_r == 10'h000)
               stable_r[t] <= terminal_i[t];
            else if (tick_r)
            begin
               if (cnt_r[t] + 10'h001 >= filt_ms_r)
               begin
                  stable_r[t] <= terminal_i[t];
                  cnt_r[t] <= 10'h000;
               end
               else
                  cnt_r[t] <= cnt_r[t] + 10'h001;
            end
         end
      end
   end

   // Gather filtered levels by assigned function
   always_comb
   begin
      roles = '0;
      for (int t = 0; t < N_TERM; t++)
      begin
         case (fsel(t, fsel_lo_r, fsel_hi_r))
            TCD_FN_FWD_RUN: roles.fwd_run = roles.fwd_run | stable_r[t];
            TCD_FN_REV_DIR: roles.rev_dir = roles.rev_dir | stable_r[t];
            TCD_FN_THREE_LINE:
               roles.three_line = roles.three_line | stable_r[t];
            TCD_FN_SEL0: roles.sel[0] = roles.sel[0] | stable_r[t];
            TCD_FN_SEL1: roles.sel[1] = roles.sel[1] | stable_r[t];
            TCD_FN_SEL2: roles.sel[2] = roles.sel[2] | stable_r[t];
            TCD_FN_SEL3: roles.sel[3] = roles.sel[3] | stable_r[t];
            TCD_FN_RAMP0: roles.ramp[0] = roles.ramp[0] | stable_r[t];
            TCD_FN_RAMP1: roles.ramp[1] = roles.ramp[1] | stable_r[t];
            TCD_FN_MOTOR0: roles.motor[0] = roles.motor[0] | stable_r[t];
            TCD_FN_MOTOR1: roles.motor[1] = roles.motor[1] | stable_r[t];
            default: roles.sel = roles.sel;
         endcase
      end
   end

   // Run command decoding
   always_comb
   begin
      latch_nxt = TCD_LS_STOP;
      run_nxt = 1'b0;
      rev_nxt = 1'b0;
      case (mode_r)
         TCD_MODE_TWO_1:
         begin
            run_nxt = roles.fwd_run ^ roles.rev_dir;
            rev_nxt = roles.rev_dir & ~roles.fwd_run;
         end
         TCD_MODE_TWO_2:
         begin
            run_nxt = roles.fwd_run;
            rev_nxt = roles.fwd_run & roles.rev_dir;
         end
         TCD_MODE_THREE_1:
         begin
            latch_nxt = latch_r;
            // Forward wins when both pulses land together
            if (!roles.three_line)
               latch_nxt = TCD_LS_STOP;
            else if (roles.fwd_run && !roles_prev_r.fwd_run)
               latch_nxt = TCD_LS_FWD;
            else if (roles.rev_dir && !roles_prev_r.rev_dir)
               latch_nxt = TCD_LS_REV;
            run_nxt = latch_nxt != TCD_LS_STOP;
            rev_nxt = latch_nxt == TCD_LS_REV;
         end
         TCD_MODE_THREE_2:
         begin
            latch_nxt = latch_r;
            if (!roles.three_line)
               latch_nxt = TCD_LS_STOP;
            else if (roles.fwd_run && !roles_prev_r.fwd_run)
               latch_nxt = TCD_LS_FWD;
            run_nxt = latch_nxt != TCD_LS_STOP;
            // Direction follows the switch live while running
            rev_nxt = run_nxt & roles.rev_dir;
         end
         default:
            latch_nxt = TCD_LS_STOP;
      endcase
   end

   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         latch_r <= TCD_LS_STOP;
         roles_prev_r <= '0;
         run_o <= 1'b0;
         reverse_o <= 1'b0;
      end
      else
      begin
         latch_r <= latch_nxt;
         roles_prev_r <= roles;
         run_o <= run_nxt;
         reverse_o <= rev_nxt;
      end
   end

   // Selections and reference outputs
   always_ff @(posedge clk_i or posedge reset_i)
   begin
      if (reset_i)
      begin
         ref_index_o <= 4'h0;
         ramp_set_o <= 2'h0;
         motor_sel_o <= 2'h0;
         ref_target_o <= TCD_TGT_SPEED;
         freq_ref_o <= 16'h0000;
         setpoint_o <= 16'h0000;
      end
      else
      begin
         ref_index_o <= roles.sel;
         ramp_set_o <= roles.ramp;
         motor_sel_o <= roles.motor;
         ref_target_o <= target_r;
         if (target_r == TCD_TGT_SPEED)
         begin
            freq_ref_o <= scale(ref_r[roles.sel], maxf_r);
            setpoint_o <= 16'h0000;
         end
         else
         begin
            freq_ref_o <= 16'h0000;
            setpoint_o <= ref_r[roles.sel];
         end
      end
   end

   always_comb
   begin
      status = 32'h0000_0000;
      status[N_TERM-1:0] = stable_r;
      status[`TCD_ST_RUN_BIT] = run_o;
      status[`TCD_ST_REV_BIT] = reverse_o;
      status[`TCD_ST_IDX_LSB +: 4] = ref_index_o;
      status[`TCD_ST_RAMP_LSB +: 2] = ramp_set_o;
      status[`TCD_ST_MOTOR_LSB +: 2] = motor_sel_o;
   end
endmodule
